// ---- test/cam_seq_chk.sv ----
`timescale 1ns/10ps
// ****
// Port checker
// ****
module cam_seq_chk
	import cam_seq_pkg::*;
#(
	parameter int CNT_W = 32,
	parameter int OUT_N = 2
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic trig_i,
	input wire logic shutter_o,
	input wire logic [OUT_N-1:0] status_o
);
	logic [31:0] ctl_ff;
	logic [31:0] exp_ff;
	logic [31:0] rd_ff;
	logic [1:0] hold_ff;
	logic [15:0] hi0_ff;
	logic [15:0] hi1_ff;
	logic wr;
	logic cw;
	logic bad;
	logic ok;
	assign wr = psel_i & penable_i & pwrite_i & pready_o;
	assign cw = wr && paddr_i == CTRL_OFS;
	// Refused writes keep the old modes
	assign bad = (pwdata_i[3:2] == SHUT_PREOPEN && pwdata_i[5:4] == TRIG_FREE)
		|| (pwdata_i[7] && pwdata_i[3] == pwdata_i[2]);
	// Outputs trail a control write, so skip two edges
	assign ok = hold_ff[1];
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctl_ff <= CTRL_RST;
		end else if (cw) begin
			ctl_ff[19:8] <= pwdata_i[19:8];
			ctl_ff[7:2] <= bad ? {ctl_ff[7], pwdata_i[6], ctl_ff[5:2]} : pwdata_i[7:2];
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			hold_ff <= 2'h0;
		end else if (cw) begin
			hold_ff <= 2'h0;
		end else if (!ok) begin
			hold_ff <= hold_ff + 2'h1;
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			exp_ff <= TIME_RST;
			rd_ff <= TIME_RST;
		end else begin
			if (wr && paddr_i == EXPOSE_OFS) exp_ff <= pwdata_i;
			if (wr && paddr_i == READOUT_OFS) rd_ff <= pwdata_i;
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			hi0_ff <= 16'h0000;
			hi1_ff <= 16'h0000;
		end else begin
			hi0_ff <= status_o[0] ? hi0_ff + 16'h0001 : 16'h0000;
			hi1_ff <= status_o[1] ? hi1_ff + 16'h0001 : 16'h0000;
		end
	end
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	closed_shutter_a: assert property (ok && ctl_ff[3:2] == SHUT_CLOSED |-> !shutter_o)
		else $error("shutter moved while held closed");
	open_shutter_a: assert property (ok && ctl_ff[3:2] == SHUT_OPEN |-> shutter_o)
		else $error("shutter moved while held open");
	const_high_a: assert property (ok && ctl_ff[18:16] == IND_HIGH |-> status_o[1])
		else $error("constant level not high");
	shut_mirror_a: assert property (ok && ctl_ff[18:16] == IND_SHUTTER && !ctl_ff[9]
		|-> status_o[1] == shutter_o) else $error("shutter indicator differs");
	shut_invert_a: assert property (ok && ctl_ff[14:12] == IND_SHUTTER && ctl_ff[8]
		|-> status_o[0] != shutter_o) else $error("inverted indicator differs");
	expose_shut_a: assert property (ok && ctl_ff[14:12] == IND_EXPOSE && !ctl_ff[8]
		&& ctl_ff[3:2] == SHUT_NORMAL |-> status_o[0] == shutter_o) else $error("shutter not on exposure");
	expose_len_a: assert property (ok && ctl_ff[14:12] == IND_EXPOSE && !ctl_ff[8]
		&& ctl_ff[5:4] != TRIG_PULSE && $fell(status_o[0]) |-> hi0_ff == exp_ff[15:0])
		else $error("exposure length wrong");
	read_len_a: assert property (ok && ctl_ff[18:16] == IND_READOUT && !ctl_ff[9]
		&& $fell(status_o[1]) |-> hi1_ff == rd_ff[15:0]) else $error("readout length wrong");
	wait_drop_a: assert property (ok && ctl_ff[14:12] == IND_WAIT && !ctl_ff[8]
		&& status_o[0] && $rose(trig_i ^ ctl_ff[6]) |-> ##1 !status_o[0])
		else $error("trigger wait did not drop");
	eff_len_a: assert property (ok && ctl_ff[14:12] == IND_EFFECT && !ctl_ff[8] && ctl_ff[7]
		&& exp_ff < rd_ff && $fell(status_o[0]) |-> hi0_ff == rd_ff[15:0])
		else $error("effective exposure length wrong");
	cover property (ok && ctl_ff[7] && ctl_ff[14:12] == IND_EFFECT && $fell(status_o[0]));
	cover property (ok && ctl_ff[5:4] == TRIG_PULSE && $fell(shutter_o));
	cover property (ctl_ff[18:16] == IND_ACQUIRE && $fell(status_o[1]));
	cover property (cw && bad);
endmodule

bind camera_exposure_trigger_sequencer cam_seq_chk #(.CNT_W(CNT_W), .OUT_N(OUT_N)) chk (
	.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
	.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .trig_i(trig_i), .shutter_o(shutter_o), .status_o(status_o)
);

// ---- test/camera_exposure_trigger_sequencer_test.sv ----
`timescale 1ns/10ps
module camera_exposure_trigger_sequencer_test import cam_seq_pkg::*;;
	typedef struct packed {
		logic [1:0] trig;
		logic [1:0] shut;
		logic fall;
		logic [1:0] frames;
		logic [1:0] ntrig;
		logic [7:0] open_n;
	} row_t;
	// ****
	// Mode, shutter, polarity, frames, triggers, open cycles
	// ****
	row_t rows [7] = '{'{TRIG_FREE, SHUT_NORMAL, 1'b0, 2'h2, 2'h0, 8'h08},
		'{TRIG_SINGLE, SHUT_CLOSED, 1'b0, 2'h2, 2'h1, 8'h00},
		'{TRIG_PERFRAME, SHUT_NORMAL, 1'b0, 2'h2, 2'h2, 8'h08},
		'{TRIG_PULSE, SHUT_NORMAL, 1'b0, 2'h2, 2'h2, 8'h0A},
		'{TRIG_PERFRAME, SHUT_CLOSED, 1'b1, 2'h2, 2'h2, 8'h00},
		'{TRIG_SINGLE, SHUT_NORMAL, 1'b0, 2'h1, 2'h1, 8'h04},
		'{TRIG_PERFRAME, SHUT_NORMAL, 1'b0, 2'h1, 2'h1, 8'h04}};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0000_0000;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic trig_i;
	logic shutter_o;
	logic [1:0] status_o;
	logic go = 1'b0;
	logic fall = 1'b0;
	logic [7:0] width = 8'h02;
	logic [7:0] shut_n = 8'h00;
	logic [7:0] shut_base = 8'h00;
	logic [31:0] rv;
	logic re;
	row_t r;
	int num_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	always #2.5 clk_i = ~clk_i;
	camera_exposure_trigger_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .trig_i(trig_i),
		.shutter_o(shutter_o), .status_o(status_o));
	trig_gen gen (.clk_i(clk_i), .rst_i(rst_i), .fall_i(fall), .go_i(go), .width_i(width),
		.trig_o(trig_i));
	always @(posedge clk_i) begin
		if (shutter_o === 1'b1) shut_n <= shut_n + 8'h01;
		cyc <= cyc + 1;
		// Longest run stays well under 1000 cycles
		if (cyc == 4000) begin
			num_errors++;
			end_sim();
		end
	end
	task end_sim();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		@(posedge clk_i);
		while (pready_o !== 1'b1) @(posedge clk_i);
		rv = prdata_o;
		re = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task fire(input logic [7:0] w);
		width <= w;
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		repeat (w + 2) @(posedge clk_i);
	endtask
	function logic [31:0] ctl(input logic [1:0] t, s, input logic f, iv, input logic [2:0] a, b);
		return 32'h0000_0001 | (32'(s) << SHUT_LSB) | (32'(t) << TRIG_LSB) | (32'(f) << FALL_BIT)
			| (32'(iv) << INV0_BIT) | (32'(a) << SEL0_LSB) | (32'(b) << SEL1_LSB);
	endfunction
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		apb(1'b1, EXPOSE_OFS, 32'h0000_0004);
		apb(1'b1, READOUT_OFS, 32'h0000_0003);
		apb(1'b1, GAP_OFS, 32'h0000_0002);
		apb(1'b1, PREOPEN_OFS, 32'h0000_0003);
		foreach (rows[i]) begin
			r = rows[i];
			fall <= r.fall;
			apb(1'b1, FRAMES_OFS, 32'(r.frames));
			shut_base = shut_n;
			apb(1'b1, CTRL_OFS, ctl(r.trig, r.shut, r.fall, 1'b0, IND_WAIT, IND_ACQUIRE));
			repeat (r.ntrig) begin
				while (status_o[0] !== 1'b1) @(posedge clk_i);
				fire(r.trig == TRIG_PULSE ? 8'h05 : 8'h02);
			end
			repeat (2) @(posedge clk_i);
			while (status_o[1] !== 1'b0) @(posedge clk_i);
			chk("open cycles", 32'(r.open_n), 32'(8'(shut_n - shut_base)));
			apb(1'b0, STATUS_OFS, 32'h0000_0000);
			chk("frames done", 32'(r.frames), 32'(rv[31:16]));
		end
		// ****
		// Awkward cases
		// ****
		apb(1'b1, FRAMES_OFS, 32'h0000_0002);
		apb(1'b1, CTRL_OFS, ctl(TRIG_PERFRAME, SHUT_NORMAL, 1'b0, 1'b0, IND_EXPOSE, IND_READOUT));
		fire(8'h02);
		fire(8'h02);
		repeat (20) @(posedge clk_i);
		apb(1'b0, STATUS_OFS, 32'h0000_0000);
		chk("late trigger", 32'h0001_0010, rv & 32'hFFFF_00FC);
		fire(8'h02);
		repeat (20) @(posedge clk_i);
		apb(1'b0, STATUS_OFS, 32'h0000_0000);
		chk("second frame", 32'h0002_0004, rv & 32'hFFFF_00FC);
		apb(1'b1, FRAMES_OFS, 32'h0000_0001);
		apb(1'b1, CTRL_OFS, ctl(TRIG_PERFRAME, SHUT_PREOPEN, 1'b0, 1'b0, IND_WAIT, IND_SHUTTER));
		while (shutter_o !== 1'b1) @(posedge clk_i);
		chk("wait early", 32'h0, 32'(status_o[0]));
		while (status_o[0] !== 1'b1) @(posedge clk_i);
		chk("preopen", 32'h1, 32'(shutter_o));
		fire(8'h02);
		repeat (12) @(posedge clk_i);
		apb(1'b1, FRAMES_OFS, 32'h0000_0000);
		apb(1'b1, CTRL_OFS, ctl(TRIG_FREE, SHUT_NORMAL, 1'b0, 1'b1, IND_SHUTTER, IND_ACQUIRE));
		repeat (30) @(posedge clk_i);
		chk("acquiring", 32'h1, 32'(status_o[1]));
		apb(1'b1, CTRL_OFS, ctl(TRIG_FREE, SHUT_NORMAL, 1'b0, 1'b1, IND_SHUTTER, IND_ACQUIRE) ^ 3);
		repeat (2) @(posedge clk_i);
		chk("halted", 32'h0, 32'(status_o[1]));
		apb(1'b1, CTRL_OFS, ctl(TRIG_FREE, SHUT_OPEN, 1'b0, 1'b0, IND_READOUT, IND_HIGH) ^ 1);
		repeat (3) @(posedge clk_i);
		chk("held open", 32'h1, 32'(shutter_o));
		chk("const high", 32'h1, 32'(status_o[1]));
		for (int k = 0; k < 2; k++) begin
			rv = ctl(TRIG_FREE, k ? SHUT_PREOPEN : SHUT_NORMAL, 1'b0, 1'b0, IND_READOUT, IND_HIGH);
			apb(1'b1, CTRL_OFS, (rv ^ 1) | (k ? 32'h0000_0000 : 32'h0000_0080));
			apb(1'b0, STATUS_OFS, 32'h0000_0000);
			chk("refused flag", 32'h1, 32'(rv[0]));
			apb(1'b0, CTRL_OFS, 32'h0000_0000);
			chk("modes kept", 32'h2, 32'(rv[7:2]));
			apb(1'b1, STATUS_OFS, 32'h0000_0001);
		end
		apb(1'b1, EXPOSE_OFS, 32'h0000_0002);
		apb(1'b1, CTRL_OFS, ctl(TRIG_FREE, SHUT_CLOSED, 1'b0, 1'b0, IND_EFFECT, 3'h7) | 32'h0000_0080);
		repeat (30) @(posedge clk_i);
		chk("inactive select", 32'h0, 32'(status_o[1]));
		chk("overlap closed", 32'h0, 32'(shutter_o));
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk("reset outputs", 32'h0, {29'h0, shutter_o, status_o});
		rst_i <= 1'b0;
		@(posedge clk_i);
		apb(1'b0, CTRL_OFS, 32'h0000_0000);
		chk("ctrl reset", CTRL_RST, rv);
		apb(1'b0, EXPOSE_OFS, 32'h0000_0000);
		chk("expose reset", TIME_RST, rv);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk("unmapped", 32'h1, {rv[30:0], re});
		end_sim();
	end
endmodule

// ---- test/trig_gen.sv ----
`timescale 1ns/10ps
// ****
// External trigger source
// ****
module trig_gen (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic fall_i,
	input wire logic go_i,
	input wire logic [7:0] width_i,
	output logic trig_o
);
	logic [7:0] left_ff;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			left_ff <= 8'h00;
		end else if (go_i) begin
			left_ff <= width_i;
		end else if (left_ff != 8'h00) begin
			left_ff <= left_ff - 8'h01;
		end
	end
	// Pulse width sets exposure in pulse mode; idle level follows polarity
	assign trig_o = (left_ff != 8'h00) ^ fall_i;
endmodule

// ---- verilog/cam_seq_pkg.sv ----
package cam_seq_pkg;
	// ***************************************************
	// Register offsets (byte addresses)
	// ***************************************************
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] EXPOSE_OFS = 8'h04;
	localparam logic [7:0] READOUT_OFS = 8'h08;
	localparam logic [7:0] GAP_OFS = 8'h0C;
	localparam logic [7:0] FRAMES_OFS = 8'h10;
	localparam logic [7:0] PREOPEN_OFS = 8'h14;
	localparam logic [7:0] STATUS_OFS = 8'h18;

	// ***************************************************
	// Control and status field positions
	// ***************************************************
	localparam int START_BIT = 0;
	localparam int HALT_BIT = 1;
	localparam int SHUT_LSB = 2;
	localparam int TRIG_LSB = 4;
	localparam int FALL_BIT = 6;
	localparam int OVL_BIT = 7;
	localparam int INV0_BIT = 8;
	localparam int INV1_BIT = 9;
	localparam int SEL0_LSB = 12;
	localparam int SEL1_LSB = 16;
	localparam int ERR_BIT = 0;

	// ***************************************************
	// Reset values
	// ***************************************************
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] TIME_RST = 32'h0000_0001;

	// ***************************************************
	// Modes, indicator codes and sequencer state encoding
	// ***************************************************
	typedef enum logic [1:0] {
		SHUT_NORMAL = 2'h0,
		SHUT_CLOSED = 2'h1,
		SHUT_OPEN = 2'h2,
		SHUT_PREOPEN = 2'h3
	} shut_mode_t;

	typedef enum logic [1:0] {
		TRIG_FREE = 2'h0,
		TRIG_SINGLE = 2'h1,
		TRIG_PERFRAME = 2'h2,
		TRIG_PULSE = 2'h3
	} trig_mode_t;

	localparam logic [2:0] IND_READOUT = 3'h0;
	localparam logic [2:0] IND_SHUTTER = 3'h1;
	localparam logic [2:0] IND_ACQUIRE = 3'h2;
	localparam logic [2:0] IND_EXPOSE = 3'h3;
	localparam logic [2:0] IND_EFFECT = 3'h4;
	localparam logic [2:0] IND_HIGH = 3'h5;
	localparam logic [2:0] IND_WAIT = 3'h6;

	typedef enum logic [5:0] {
		ST_IDLE = 6'b00_0001,
		ST_PREOPEN = 6'b00_0010,
		ST_WAIT = 6'b00_0100,
		ST_EXPOSE = 6'b00_1000,
		ST_READ = 6'b01_0000,
		ST_GAP = 6'b10_0000
	} seq_state_t;
endpackage

// ---- verilog/camera_exposure_trigger_sequencer.sv ----
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module camera_exposure_trigger_sequencer
	import cam_seq_pkg::*;
#(
	parameter int CNT_W = 32,
	parameter int OUT_N = 2
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic trig_i,
	output logic shutter_o,
	output logic [OUT_N-1:0] status_o
);
	// ***************************************************
	// Register file
	// ***************************************************
	logic [31:0] ctrl_ff;
	logic [CNT_W-1:0] expose_ff;
	logic [CNT_W-1:0] read_ff;
	logic [CNT_W-1:0] gap_ff;
	logic [CNT_W-1:0] frames_ff;
	logic [CNT_W-1:0] preopen_ff;
	logic err_ff;
	logic [31:0] prdata_ff;
	logic setup;
	logic wr;
	logic mapped;
	logic start_req;
	logic halt_req;
	logic cfg_bad;
	logic [31:0] nxt_ctrl;
	logic [31:0] eff_ctrl;
	shut_mode_t smode;
	trig_mode_t tmode;
	logic falling;
	logic overlap;

	// ***************************************************
	// Sequencer state
	// ***************************************************
	seq_state_t state_ff;
	seq_state_t nxt_state;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic [CNT_W-1:0] done_ff;
	logic acq_ff;
	logic act_prev_ff;
	logic act_lvl;
	logic act_edge;
	logic inact_edge;
	logic last_frame;
	logic timer_done;
	logic short_exp;
	logic shut_open;
	logic shutter_ff;
	logic [OUT_N-1:0] status_ff;
	logic [6:0] ind;

	// Modes of a control write act in its own cycle, so a start sees them
	assign eff_ctrl = (wr && paddr_i == CTRL_OFS) ? nxt_ctrl : ctrl_ff;
	assign smode = shut_mode_t'(eff_ctrl[SHUT_LSB +: 2]);
	assign tmode = trig_mode_t'(eff_ctrl[TRIG_LSB +: 2]);
	assign falling = eff_ctrl[FALL_BIT];
	assign overlap = eff_ctrl[OVL_BIT];

	// ***************************************************
	// APB slave, zero wait states
	// ***************************************************
	assign setup = psel_i & ~penable_i;
	assign wr = psel_i & penable_i & pwrite_i;
	assign pready_o = 1'b1;
	assign prdata_o = prdata_ff;

	always_comb begin
		if (paddr_i == CTRL_OFS) begin
			mapped = 1'b1;
		end else if (paddr_i == EXPOSE_OFS || paddr_i == READOUT_OFS) begin
			mapped = 1'b1;
		end else if (paddr_i == GAP_OFS || paddr_i == FRAMES_OFS) begin
			mapped = 1'b1;
		end else if (paddr_i == PREOPEN_OFS || paddr_i == STATUS_OFS) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	end

	assign pslverr_o = psel_i & penable_i & ~mapped;

	// Read data captured in setup so it is stable through the access phase
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prdata_ff <= 32'h0000_0000;
		end else if (setup) begin
			if (paddr_i == CTRL_OFS) begin
				prdata_ff <= {ctrl_ff[31:2], 2'b00};
			end else if (paddr_i == EXPOSE_OFS) begin
				prdata_ff <= 32'(expose_ff);
			end else if (paddr_i == READOUT_OFS) begin
				prdata_ff <= 32'(read_ff);
			end else if (paddr_i == GAP_OFS) begin
				prdata_ff <= 32'(gap_ff);
			end else if (paddr_i == FRAMES_OFS) begin
				prdata_ff <= 32'(frames_ff);
			end else if (paddr_i == PREOPEN_OFS) begin
				prdata_ff <= 32'(preopen_ff);
			end else if (paddr_i == STATUS_OFS) begin
				prdata_ff <= {done_ff[15:0], 5'h00, acq_ff, 2'b00, state_ff, 1'b0, err_ff};
			end else begin
				prdata_ff <= 32'h0000_0000;
			end
		end
	end

	// Illegal shutter/trigger/overlap combinations keep the old shutter mode, trigger mode and overlap bit
	always_comb begin
		nxt_ctrl = pwdata_i;
		nxt_ctrl[START_BIT] = 1'b0;
		nxt_ctrl[HALT_BIT] = 1'b0;
		cfg_bad = 1'b0;
		if (pwdata_i[SHUT_LSB +: 2] == SHUT_PREOPEN && pwdata_i[TRIG_LSB +: 2] == TRIG_FREE) begin
			cfg_bad = 1'b1;
		end
		if (pwdata_i[OVL_BIT] && (pwdata_i[SHUT_LSB +: 2] == SHUT_NORMAL ||
				pwdata_i[SHUT_LSB +: 2] == SHUT_PREOPEN)) begin
			cfg_bad = 1'b1;
		end
		if (cfg_bad) begin
			nxt_ctrl[SHUT_LSB +: 2] = ctrl_ff[SHUT_LSB +: 2];
			nxt_ctrl[OVL_BIT] = ctrl_ff[OVL_BIT];
			nxt_ctrl[TRIG_LSB +: 2] = ctrl_ff[TRIG_LSB +: 2];
		end
	end

	assign start_req = wr && paddr_i == CTRL_OFS && pwdata_i[START_BIT];
	assign halt_req = wr && paddr_i == CTRL_OFS && pwdata_i[HALT_BIT];

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_ff <= CTRL_RST;
		end else if (wr && paddr_i == CTRL_OFS) begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			expose_ff <= CNT_W'(TIME_RST);
			read_ff <= CNT_W'(TIME_RST);
			gap_ff <= CNT_W'(TIME_RST);
			frames_ff <= CNT_W'(TIME_RST);
			preopen_ff <= CNT_W'(TIME_RST);
		end else if (wr) begin
			if (paddr_i == EXPOSE_OFS) begin
				expose_ff <= CNT_W'(pwdata_i);
			end else if (paddr_i == READOUT_OFS) begin
				read_ff <= CNT_W'(pwdata_i);
			end else if (paddr_i == GAP_OFS) begin
				gap_ff <= CNT_W'(pwdata_i);
			end else if (paddr_i == FRAMES_OFS) begin
				frames_ff <= CNT_W'(pwdata_i);
			end else if (paddr_i == PREOPEN_OFS) begin
				preopen_ff <= CNT_W'(pwdata_i);
			end
		end
	end

	// Sticky refusal flag, write one to clear; a new refusal wins
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			err_ff <= 1'b0;
		end else if (wr && paddr_i == CTRL_OFS && cfg_bad) begin
			err_ff <= 1'b1;
		end else if (wr && paddr_i == STATUS_OFS && pwdata_i[ERR_BIT]) begin
			err_ff <= 1'b0;
		end
	end

	// ***************************************************
	// Trigger edge detection
	// ***************************************************
	assign act_lvl = trig_i ^ falling;
	assign act_edge = act_lvl & ~act_prev_ff;
	assign inact_edge = ~act_lvl & act_prev_ff;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			act_prev_ff <= 1'b0;
		end else begin
			act_prev_ff <= act_lvl;
		end
	end

	// ***************************************************
	// Frame sequencer
	// ***************************************************
	// Zero frames means run until halted
	assign last_frame = frames_ff != '0 && done_ff + CNT_W'(1) >= frames_ff;
	assign timer_done = cnt_ff <= CNT_W'(1);
	assign short_exp = expose_ff < read_ff;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff - CNT_W'(1);
		case (state_ff)
			ST_IDLE: begin
				if (start_req) begin
					if (tmode == TRIG_FREE) begin
						nxt_state = ST_EXPOSE;
						nxt_cnt = expose_ff;
					end else if (smode == SHUT_PREOPEN) begin
						nxt_state = ST_PREOPEN;
						nxt_cnt = preopen_ff;
					end else begin
						nxt_state = ST_WAIT;
					end
				end
			end
			ST_PREOPEN: begin
				if (timer_done) begin
					nxt_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (act_edge) begin
					nxt_state = ST_EXPOSE;
					nxt_cnt = expose_ff;
				end
			end
			ST_EXPOSE: begin
				if (tmode == TRIG_PULSE) begin
					if (inact_edge) begin
						nxt_state = ST_READ;
						nxt_cnt = read_ff;
					end
				end else if (timer_done) begin
					nxt_state = ST_READ;
					nxt_cnt = read_ff;
				end
			end
			ST_READ: begin
				if (timer_done) begin
					if (last_frame) begin
						nxt_state = ST_IDLE;
					end else if (tmode == TRIG_FREE || tmode == TRIG_SINGLE) begin
						nxt_state = ST_GAP;
						nxt_cnt = gap_ff;
					end else if (smode == SHUT_PREOPEN) begin
						nxt_state = ST_PREOPEN;
						nxt_cnt = preopen_ff;
					end else begin
						nxt_state = ST_WAIT;
					end
				end
			end
			ST_GAP: begin
				if (timer_done) begin
					nxt_state = ST_EXPOSE;
					nxt_cnt = expose_ff;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		if (halt_req) begin
			nxt_state = ST_IDLE;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff <= ST_IDLE;
			cnt_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			done_ff <= '0;
		end else if (state_ff == ST_IDLE && start_req) begin
			done_ff <= '0;
		end else if (state_ff == ST_READ && timer_done) begin
			done_ff <= done_ff + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			acq_ff <= 1'b0;
		end else if (nxt_state == ST_IDLE) begin
			acq_ff <= 1'b0;
		end else if (nxt_state == ST_EXPOSE) begin
			acq_ff <= 1'b1;
		end
	end

	// ***************************************************
	// Shutter drive
	// ***************************************************
	always_comb begin
		case (smode)
			SHUT_NORMAL: shut_open = nxt_state == ST_EXPOSE;
			SHUT_CLOSED: shut_open = 1'b0;
			SHUT_OPEN: shut_open = 1'b1;
			SHUT_PREOPEN: shut_open = nxt_state == ST_PREOPEN || nxt_state == ST_WAIT ||
				nxt_state == ST_EXPOSE;
			default: shut_open = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			shutter_ff <= 1'b0;
		end else begin
			shutter_ff <= shut_open;
		end
	end

	assign shutter_o = shutter_ff;

	// ***************************************************
	// Status outputs
	// ***************************************************
	// Indicators decoded from next state so outputs align with the state register
	assign ind[IND_READOUT] = nxt_state == ST_READ;
	assign ind[IND_SHUTTER] = shut_open;
	assign ind[IND_ACQUIRE] = nxt_state != ST_IDLE && (acq_ff || nxt_state == ST_EXPOSE);
	assign ind[IND_EXPOSE] = nxt_state == ST_EXPOSE;
	assign ind[IND_EFFECT] = (overlap && short_exp) ? (nxt_state == ST_READ) :
		(nxt_state == ST_EXPOSE);
	assign ind[IND_HIGH] = 1'b1;
	assign ind[IND_WAIT] = nxt_state == ST_WAIT;

	genvar g;
	generate
		for (g = 0; g < OUT_N; g++) begin : g_out
			logic [2:0] sel;
			logic inv;
			assign sel = ctrl_ff[SEL0_LSB + 4*g +: 3];
			assign inv = ctrl_ff[INV0_BIT + g];
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					status_ff[g] <= 1'b0;
				end else if (sel == IND_HIGH) begin
					status_ff[g] <= 1'b1;
				end else if (sel > IND_WAIT) begin
					status_ff[g] <= inv;
				end else begin
					status_ff[g] <= ind[sel] ^ inv;
				end
			end
		end
	endgenerate

	assign status_o = status_ff;
endmodule
